// ===== src/gpib_pkg.sv
`default_nettype none
package gpib_pkg;
  // Multiline command layout (7-bit code on the data lines)
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [4:0] UNADDR_CODE = 5'h1F;
  localparam int GRP_HI = 6;
  localparam int GRP_LO = 5;
  localparam int ADDR_HI = 4;
  localparam int ADDR_LO = 0;
  // Settle time after attention falls, controller side
  localparam int CLK_PERIOD_NS = 5;
  localparam int ATN_SETTLE_NS = 100;
  localparam int ATN_SETTLE_CYC =
    (ATN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] SETTLE_LAST = 6'(ATN_SETTLE_CYC - 1);
  localparam logic [7:0] BYTE_IDLE = 8'h00;
  localparam logic [4:0] ADDR_RESET = 5'h00;
endpackage : gpib_pkg
`default_nettype wire

// ===== src/gpib_bus_if.sv
`default_nettype none
// Wired-OR bus: a line reads low (asserted) if any party drives it.
// Each *_oe asserts the line (pulls low); read values are logic-true.
interface gpib_bus_if;
  logic [7:0] dio_dev_oe;
  logic [7:0] dio_ctl_oe;
  logic dav_dev_oe, dav_ctl_oe;
  logic nrfd_dev_oe, nrfd_ctl_oe;
  logic ndac_dev_oe, ndac_ctl_oe;
  logic eoi_dev_oe, eoi_ctl_oe;
  logic srq_dev_oe;
  logic atn_ctl_oe, ifc_ctl_oe, ren_ctl_oe;
  // Logic-true levels of each wire
  logic [7:0] dio;
  logic dav, nrfd, ndac, eoi, srq, atn, ifc, ren;
  assign dio = dio_dev_oe | dio_ctl_oe;
  assign dav = dav_dev_oe | dav_ctl_oe;
  assign nrfd = nrfd_dev_oe | nrfd_ctl_oe;
  assign ndac = ndac_dev_oe | ndac_ctl_oe;
  assign eoi = eoi_dev_oe | eoi_ctl_oe;
  assign srq = srq_dev_oe;
  assign atn = atn_ctl_oe;
  assign ifc = ifc_ctl_oe;
  assign ren = ren_ctl_oe;
  modport dev (
    output dio_dev_oe, dav_dev_oe, nrfd_dev_oe, ndac_dev_oe,
    output eoi_dev_oe, srq_dev_oe,
    input dio, dav, nrfd, ndac, eoi, srq, atn, ifc, ren
  );
  modport ctl (
    output dio_ctl_oe, dav_ctl_oe, nrfd_ctl_oe, ndac_ctl_oe,
    output eoi_ctl_oe, atn_ctl_oe, ifc_ctl_oe, ren_ctl_oe,
    input dio, dav, nrfd, ndac, eoi, srq, atn, ifc, ren
  );
endinterface : gpib_bus_if
`default_nettype wire

// ===== src/hs_engine.sv
`default_nettype none
// Shared interlocked source/acceptor handshake for one party
module hs_engine (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clear_i,
  input wire logic src_en_i,
  input wire logic acc_en_i,
  input wire logic src_go_i,
  input wire logic [7:0] src_byte_i,
  input wire logic src_end_i,
  input wire logic sink_ready_i,
  input wire logic dav_i,
  input wire logic nrfd_i,
  input wire logic ndac_i,
  input wire logic eoi_i,
  input wire logic [7:0] dio_i,
  output logic [7:0] dio_oe_o,
  output logic dav_oe_o,
  output logic eoi_oe_o,
  output logic nrfd_oe_o,
  output logic ndac_oe_o,
  output logic src_busy_o,
  output logic src_done_o,
  output logic acc_valid_o,
  output logic [7:0] acc_byte_o,
  output logic acc_end_o
);
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_VALID, S_DROP} src_t;
  typedef enum logic [1:0] {A_READY, A_TAKE, A_DONE} acc_t;
  src_t src_q, src_d;
  acc_t acc_q, acc_d;
  logic [7:0] dbyte_q;
  logic dend_q;
  logic [7:0] rbyte_q;
  logic rend_q, rvalid_q;
  // Readiness: NRFD released and NDAC still held
  wire src_ready = !nrfd_i && ndac_i;

  // Source sequence
  always_comb begin
    src_d = src_q;
    case (src_q)
      S_IDLE: if (src_go_i && src_en_i) src_d = S_WAIT;
      S_WAIT: if (src_ready) src_d = S_VALID;
      S_VALID: if (!ndac_i) src_d = S_DROP;
      S_DROP: src_d = S_IDLE;
      default: src_d = S_IDLE;
    endcase
    if (clear_i || !src_en_i) src_d = S_IDLE;
  end

  // Acceptor sequence; a sink stall keeps NRFD asserted
  always_comb begin
    acc_d = acc_q;
    case (acc_q)
      A_READY: if (dav_i && sink_ready_i) acc_d = A_TAKE;
      A_TAKE: acc_d = A_DONE;
      A_DONE: if (!dav_i) acc_d = A_READY;
      default: acc_d = A_READY;
    endcase
    if (clear_i || !acc_en_i) acc_d = A_READY;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      src_q <= S_IDLE;
      acc_q <= A_READY;
      dbyte_q <= gpib_pkg::BYTE_IDLE;
      dend_q <= 1'b0;
      rbyte_q <= gpib_pkg::BYTE_IDLE;
      rend_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      src_q <= src_d;
      acc_q <= acc_d;
      if (src_q == S_IDLE && src_d == S_WAIT) begin
        dbyte_q <= src_byte_i;
        dend_q <= src_end_i;
      end
      // Latch while DAV held, before NDAC release
      if (acc_q == A_READY && acc_d == A_TAKE) begin
        rbyte_q <= dio_i;
        rend_q <= eoi_i;
      end
      rvalid_q <= (acc_q == A_READY && acc_d == A_TAKE);
    end
  end

  // Data drive only while sourcing; same engine for data and commands
  assign dio_oe_o = (src_q != S_IDLE) ? dbyte_q : 8'h00;
  assign dav_oe_o = (src_q == S_VALID);
  assign eoi_oe_o = (src_q != S_IDLE) && dend_q;
  // Acceptor drives NRFD/NDAC only when enabled
  assign nrfd_oe_o = acc_en_i &&
    (acc_q != A_READY || !sink_ready_i);
  assign ndac_oe_o = acc_en_i && (acc_q == A_READY);
  assign src_busy_o = (src_q != S_IDLE);
  assign src_done_o = (src_q == S_DROP);
  assign acc_valid_o = rvalid_q;
  assign acc_byte_o = rbyte_q;
  assign acc_end_o = rend_q;
endmodule : hs_engine
`default_nettype wire

// ===== src/gpib_device.sv
`default_nettype none
// What this block does
// - All bus lines are active low
// - Attention splits commands from data
// - Eight parallel bidirectional data lines
// - Source drives DAV, acceptors NRFD/NDAC
// - Source waits NRFD high, NDAC low
// - Controller waits 100ns after attention
// - Source asserts DAV when ready
// - Acceptors hold NDAC until byte taken
// - NDAC high makes source release DAV
// - DAV high makes acceptors reassert NDAC
// - NRFD released when acceptor ready
// - Same handshake for commands and data
// - Commands with attention, data without
// - Interface clear resets bus state
// - Interface clear idles talker and listener
// - Remote enable selects remote operation
// - End line marks the final byte
// - Device pulls service request when needed
// - Talk/listen only after own address
// - Only one talker at a time
module gpib_device (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  gpib_bus_if.dev bus,
  input wire logic [4:0] my_addr_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_last_i,
  input wire logic rx_ready_i,
  input wire logic srq_req_i,
  output logic tx_done_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_last_o,
  output logic cmd_valid_o,
  output logic [7:0] cmd_byte_o,
  output logic talker_o,
  output logic listener_o,
  output logic remote_o,
  output logic if_clear_o
);
  logic talk_q, listen_q, remote_q, clear_q;
  logic rxv_q, rxl_q, cmdv_q, done_q;
  logic [7:0] rxb_q, cmdb_q;
  logic acc_valid, acc_end, src_done;
  logic [7:0] acc_byte;
  // Bus levels come in logic-true from the interface
  wire atn = bus.atn;
  wire ifc = bus.ifc;
  // Acceptor is always on for commands; for data only when listening
  wire acc_en = atn || listen_q;
  wire src_en = talk_q && !atn;

  hs_engine u_hs (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clear_i(ifc),
    .src_en_i(src_en),
    .acc_en_i(acc_en),
    .src_go_i(tx_valid_i),
    .src_byte_i(tx_byte_i),
    .src_end_i(tx_last_i),
    .sink_ready_i(atn || rx_ready_i),
    .dav_i(bus.dav),
    .nrfd_i(bus.nrfd),
    .ndac_i(bus.ndac),
    .eoi_i(bus.eoi),
    .dio_i(bus.dio),
    .dio_oe_o(bus.dio_dev_oe),
    .dav_oe_o(bus.dav_dev_oe),
    .eoi_oe_o(bus.eoi_dev_oe),
    .nrfd_oe_o(bus.nrfd_dev_oe),
    .ndac_oe_o(bus.ndac_dev_oe),
    .src_busy_o(),
    .src_done_o(src_done),
    .acc_valid_o(acc_valid),
    .acc_byte_o(acc_byte),
    .acc_end_o(acc_end)
  );

  // Command decode from the captured byte
  wire [1:0] grp = acc_byte[gpib_pkg::GRP_HI:gpib_pkg::GRP_LO];
  wire [4:0] addr = acc_byte[gpib_pkg::ADDR_HI:gpib_pkg::ADDR_LO];
  wire is_cmd = acc_valid && atn;
  wire is_data = acc_valid && !atn;
  wire lag = is_cmd && grp == gpib_pkg::GRP_LISTEN;
  wire tag = is_cmd && grp == gpib_pkg::GRP_TALK;
  wire unl = lag && addr == gpib_pkg::UNADDR_CODE;
  wire unt = tag && addr == gpib_pkg::UNADDR_CODE;
  wire my_lag = lag && addr == my_addr_i;
  wire my_tag = tag && addr == my_addr_i;
  // Another talker address untalks us, keeping a single talker
  wire other_tag = tag && !unt && addr != my_addr_i;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || ifc) begin
      talk_q <= 1'b0;
      listen_q <= 1'b0;
    end else begin
      if (my_tag) talk_q <= 1'b1;
      else if (unt || other_tag) talk_q <= 1'b0;
      if (my_lag) listen_q <= 1'b1;
      else if (unl) listen_q <= 1'b0;
    end
  end

  // Status, remote mode, received bytes
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      remote_q <= 1'b0;
      clear_q <= 1'b0;
      rxv_q <= 1'b0;
      rxl_q <= 1'b0;
      rxb_q <= gpib_pkg::BYTE_IDLE;
      cmdv_q <= 1'b0;
      cmdb_q <= gpib_pkg::BYTE_IDLE;
      done_q <= 1'b0;
    end else begin
      remote_q <= bus.ren;
      clear_q <= ifc;
      rxv_q <= is_data;
      rxl_q <= is_data && acc_end;
      if (is_data) rxb_q <= acc_byte;
      cmdv_q <= is_cmd;
      if (is_cmd) cmdb_q <= acc_byte;
      done_q <= src_done;
    end
  end

  // Service request is a plain level from the instrument
  assign bus.srq_dev_oe = srq_req_i && !reset_i;
  assign tx_done_o = done_q;
  assign rx_valid_o = rxv_q;
  assign rx_byte_o = rxb_q;
  assign rx_last_o = rxl_q;
  assign cmd_valid_o = cmdv_q;
  assign cmd_byte_o = cmdb_q;
  assign talker_o = talk_q;
  assign listener_o = listen_q;
  assign remote_o = remote_q;
  assign if_clear_o = clear_q;
endmodule : gpib_device
`default_nettype wire

// ===== src/gpib_controller.sv
`default_nettype none
// System controller end: sources commands and data, accepts data
module gpib_controller (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  gpib_bus_if.ctl bus,
  input wire logic atn_i,
  input wire logic ifc_i,
  input wire logic ren_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_last_i,
  input wire logic listen_i,
  input wire logic rx_ready_i,
  output logic tx_done_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_last_o,
  output logic srq_o
);
  logic atn_q, ifc_q, ren_q, srq_q;
  logic [5:0] settle_q;
  logic src_done;
  // Hold off sourcing until handshake lines settle after attention
  wire settled = (settle_q == gpib_pkg::SETTLE_LAST);

  hs_engine u_hs (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clear_i(1'b0),
    .src_en_i(atn_q ? settled : !listen_i),
    .acc_en_i(listen_i && !atn_q),
    .src_go_i(tx_valid_i),
    .src_byte_i(tx_byte_i),
    .src_end_i(tx_last_i && !atn_q),
    .sink_ready_i(rx_ready_i),
    .dav_i(bus.dav),
    .nrfd_i(bus.nrfd),
    .ndac_i(bus.ndac),
    .eoi_i(bus.eoi),
    .dio_i(bus.dio),
    .dio_oe_o(bus.dio_ctl_oe),
    .dav_oe_o(bus.dav_ctl_oe),
    .eoi_oe_o(bus.eoi_ctl_oe),
    .nrfd_oe_o(bus.nrfd_ctl_oe),
    .ndac_oe_o(bus.ndac_ctl_oe),
    .src_busy_o(),
    .src_done_o(src_done),
    .acc_valid_o(rx_valid_o),
    .acc_byte_o(rx_byte_o),
    .acc_end_o(rx_last_o)
  );

  // Management lines and settle counter
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      atn_q <= 1'b0;
      ifc_q <= 1'b0;
      ren_q <= 1'b0;
      srq_q <= 1'b0;
      settle_q <= 6'h00;
    end else begin
      atn_q <= atn_i;
      ifc_q <= ifc_i;
      ren_q <= ren_i;
      srq_q <= bus.srq;
      if (!atn_q) settle_q <= 6'h00;
      else if (!settled) settle_q <= settle_q + 6'h01;
    end
  end

  assign bus.atn_ctl_oe = atn_q;
  assign bus.ifc_ctl_oe = ifc_q;
  assign bus.ren_ctl_oe = ren_q;
  assign tx_done_o = src_done;
  assign srq_o = srq_q;
endmodule : gpib_controller
`default_nettype wire

// ===== bench/ieee488_bus_handshake_asserts.sv
`default_nettype none
module ieee488_bus_handshake_asserts (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] dio,
  input wire logic [7:0] dio_dev_oe,
  input wire logic dav,
  input wire logic nrfd,
  input wire logic ndac,
  input wire logic eoi,
  input wire logic atn,
  input wire logic dav_dev_oe,
  input wire logic dav_ctl_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Source side of the interlock
  AST_DAV_READY: assert property ($rose(dav) |-> $past(!nrfd && ndac))
    else $error("data valid raised while acceptors not ready");
  AST_DAV_HOLD: assert property (dav && ndac |=> dav)
    else $error("data valid dropped before byte accepted");
  AST_DAV_DROP: assert property ($fell(dav) |-> $past(!ndac))
    else $error("data valid dropped without acceptance");
  AST_DIO_STABLE: assert property (dav && $past(dav) |-> $stable(dio))
    else $error("data lines moved while valid");
  // Acceptor side of the interlock
  AST_NRFD_TAKE: assert property ($rose(dav) |-> ##[0:3] nrfd)
    else $error("not-ready not asserted after data valid");
  AST_NDAC_BACK: assert property ($fell(dav) |-> ##[1:4] ndac)
    else $error("not-accepted not reasserted after release");
  // Ownership: one source, and the device never talks under attention
  AST_ONE_SOURCE: assert property (!(dav_dev_oe && dav_ctl_oe))
    else $error("two parties drive data valid");
  AST_DEV_QUIET_ATN: assert property (atn |-> dio_dev_oe == 8'h00)
    else $error("device drives data lines under attention");
  cover property ($fell(dav) && atn);
  cover property ($fell(dav) && !atn && !dav_dev_oe);
  cover property (dav && eoi && dav_dev_oe);
endmodule : ieee488_bus_handshake_asserts
`default_nettype wire

// ===== bench/ieee488_bus_handshake_tb_top.sv
`default_nettype none
module ieee488_bus_handshake_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, reset_i, atn, ifc, ren, listen, srq;
  logic c_txv, d_txv, txl, c_rdy, d_rdy, got_end;
  logic c_done, d_done, d_rxv, d_cmdv, c_rxv, c_rxl, d_rxl;
  logic talker, listener, remote, clr, c_srq;
  logic [7:0] txb, got, c_rxb, d_rxb, d_cmdb;
  logic [4:0] addr;
  int fail_count, compares;
  gpib_bus_if bus ();
  gpib_device u_gpib_device (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .bus(bus.dev), .my_addr_i(addr), .tx_valid_i(d_txv),
    .tx_byte_i(txb), .tx_last_i(txl), .rx_ready_i(d_rdy),
    .srq_req_i(srq), .tx_done_o(d_done), .rx_valid_o(d_rxv),
    .rx_byte_o(d_rxb), .rx_last_o(d_rxl), .cmd_valid_o(d_cmdv),
    .cmd_byte_o(d_cmdb), .talker_o(talker), .listener_o(listener),
    .remote_o(remote), .if_clear_o(clr));
  gpib_controller u_gpib_controller (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .bus(bus.ctl), .atn_i(atn), .ifc_i(ifc),
    .ren_i(ren), .tx_valid_i(c_txv), .tx_byte_i(txb), .tx_last_i(txl),
    .listen_i(listen), .rx_ready_i(c_rdy), .tx_done_o(c_done),
    .rx_valid_o(c_rxv), .rx_byte_o(c_rxb), .rx_last_o(c_rxl),
    .srq_o(c_srq));
  ieee488_bus_handshake_asserts u_asserts (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .dio(bus.dio), .dio_dev_oe(bus.dio_dev_oe),
    .dav(bus.dav), .nrfd(bus.nrfd), .ndac(bus.ndac), .eoi(bus.eoi),
    .atn(bus.atn), .dav_dev_oe(bus.dav_dev_oe),
    .dav_ctl_oe(bus.dav_ctl_oe));
  // 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // Latch the latest byte handed to either user side
  always @(posedge sys_clk_i) begin
    if (d_cmdv) got <= d_cmdb;
    if (d_rxv) {got_end, got} <= {d_rxl, d_rxb};
    if (c_rxv) {got_end, got} <= {c_rxl, c_rxb};
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Valid drops once the bus shows the byte, so it cannot be taken twice
  task automatic send(input logic ctl, input logic [7:0] b,
                      input logic l);
    int n;
    @(negedge sys_clk_i);
    txb = b;
    txl = l;
    if (ctl) c_txv = 1'b1;
    else d_txv = 1'b1;
    for (n = 0; n < 400 && !bus.dav; n++) @(negedge sys_clk_i);
    c_txv = 1'b0;
    d_txv = 1'b0;
    for (n = 0; n < 400 && !(c_done || d_done); n++)
      @(negedge sys_clk_i);
    if (n == 400) chk(8'h00, 8'h01);
    repeat (3) @(negedge sys_clk_i);
  endtask : send
  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    final_report();
  end
  initial begin
    {atn, ifc, ren, listen, srq, c_txv, d_txv, txl} = 8'h00;
    {c_rdy, d_rdy, reset_i} = 3'h7;
    {txb, addr, fail_count, compares} = 0;
    // Address must be in place before the listen command arrives
    addr = 5'h0C;
    repeat (12) @(negedge sys_clk_i);
    reset_i = 1'b0;
    atn = 1'b1;
    ren = 1'b1;
    repeat (25) @(negedge sys_clk_i);
    send(1'b1, {1'b0, gpib_pkg::GRP_LISTEN, 5'h0C}, 1'b0);
    chk(got, {1'b0, gpib_pkg::GRP_LISTEN, 5'h0C});
    chk(listener, 8'h01);
    chk(remote, 8'h01);
    $display("test listen done");
    // Data bytes; the stalled sink must hold the source off
    atn = 1'b0;
    d_rdy = 1'b0;
    fork
      send(1'b1, 8'hA5, 1'b0);
      begin
        repeat (12) @(negedge sys_clk_i);
        chk(bus.dav, 8'h00);
        d_rdy = 1'b1;
      end
    join
    chk(got, 8'hA5);
    chk(got_end, 8'h00);
    send(1'b1, 8'h5A, 1'b1);
    chk(got, 8'h5A);
    chk(got_end, 8'h01);
    $display("test data done");
    // Unlisten, talk, then lose talk to another address
    atn = 1'b1;
    repeat (25) @(negedge sys_clk_i);
    send(1'b1, {1'b0, gpib_pkg::GRP_LISTEN, gpib_pkg::UNADDR_CODE}, 1'b0);
    chk(listener, 8'h00);
    send(1'b1, {1'b0, gpib_pkg::GRP_TALK, 5'h0C}, 1'b0);
    chk(talker, 8'h01);
    atn = 1'b0;
    listen = 1'b1;
    send(1'b0, 8'h3C, 1'b1);
    chk(got, 8'h3C);
    chk(got_end, 8'h01);
    listen = 1'b0;
    atn = 1'b1;
    repeat (25) @(negedge sys_clk_i);
    send(1'b1, {1'b0, gpib_pkg::GRP_TALK, 5'h0D}, 1'b0);
    chk(talker, 8'h00);
    $display("test talk done");
    // Interface clear idles a talker; service request reaches controller
    send(1'b1, {1'b0, gpib_pkg::GRP_TALK, 5'h0C}, 1'b0);
    ifc = 1'b1;
    srq = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk(clr, 8'h01);
    chk(talker, 8'h00);
    chk(c_srq, 8'h01);
    ifc = 1'b0;
    $display("test clear done");
    final_report();
  end
endmodule : ieee488_bus_handshake_tb_top
`default_nettype wire
